// ==== pio_apb_slave.sv ====
// APB slave front end: decodes word index and access strobes
`timescale 1ns/1ps
`default_nettype none
module pio_apb_slave (
    input wire pio_pkg::apb_req_t req,
    output pio_pkg::apb_rsp_t rsp,
    input wire logic [7:0] rd_byte,
    output logic [4:0] index,
    output logic wr_stb,
    output logic rd_stb
);
    import pio_pkg::*;
    // Zero wait states: every access completes in its first access cycle
    assign index = req.paddr[6:2];
    assign wr_stb = req.psel && req.penable && req.pwrite;
    assign rd_stb = req.psel && req.penable && !req.pwrite;
    assign rsp.pready = 1'b1;
    assign rsp.pslverr = 1'b0;
    assign rsp.prdata = {24'h000000, rd_byte};
endmodule : pio_apb_slave
`default_nettype wire

// ==== pio_card.sv ====
// Parallel I/O card register file and data path
//
// Functional notes
// R1: Register 0 reads 1 when ready for another transfer, else 0.
// R2: Register 1 always reads the fixed card identity, no side effect.
// R3: Input word high byte at register 4, low byte at register 5.
// R4: Register 7: ok, request low, status one low, status zero low.
// R5: Non-zero write to register 0 sets peripheral control; zero ignored.
// R6: Non-zero write to register 1 resets the card.
// R7: Register 2 bit 0 enables external request interrupts.
// R8: Register 3: bit 7 global irq, bits 3..0 DMA enables.
// R9: Output word high byte via register 4, low byte via register 5.
// R10: Register 7 low bits drive control outputs; 1 means low.
// R11: Control outputs hold until rewritten; card reset leaves them.
// R12: Peripheral status bits are live, never latched.
// R13: Register 3 reads enables, request, level switches, DMA enables.
// R14: Undefined offsets ignore writes and read zero.
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module pio_card (
    input wire logic mclk,
    input wire logic reset_n,
    input wire pio_pkg::apb_req_t apb_req,
    output pio_pkg::apb_rsp_t apb_rsp,
    input wire pio_pkg::periph_in_t periph_in,
    input wire logic [1:0] level_switch,
    input wire logic [15:0] input_word,
    input wire logic input_valid,
    output logic input_ready,
    output logic [15:0] output_word,
    output logic output_valid,
    input wire logic output_ready,
    output logic peripheral_control_line,
    output logic control_output_zero,
    output logic control_output_one,
    output logic irq_request,
    output logic [3:0] dma_enables,
    output logic card_reset_pulse
);
    import pio_pkg::*;

    logic [4:0] index;
    logic wr_stb;
    logic rd_stb;
    logic [7:0] rd_byte;
    logic [7:0] wbyte;
    logic soft_reset;

    logic periph_ctl_q;
    logic ext_mask_q;
    logic irq_en_q;
    logic [3:0] dma_en_q;
    logic [7:0] out_hi_q;
    logic [1:0] ctl_q;
    logic [15:0] in_word_q;
    logic in_word_full_q;
    logic reset_pulse_q;

    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [15:0] fifo_out_data;

    pio_apb_slave u_bus (
        .req(apb_req),
        .rsp(apb_rsp),
        .rd_byte(rd_byte),
        .index(index),
        .wr_stb(wr_stb),
        .rd_stb(rd_stb)
    );

    assign wbyte = apb_req.pwdata[7:0];
    // Card reset: non-zero write to register 1
    assign soft_reset = wr_stb && (index == reg_card_reset_idx())
        && (wbyte != 8'h00); // R6

    function automatic logic [4:0] reg_card_reset_idx();
        return reg_ident_idx;
    endfunction : reg_card_reset_idx

    // Peripheral control: set by non-zero write, cleared by card reset
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            periph_ctl_q <= 1'b0;
        end else if (wr_stb && index == reg_ready_idx && wbyte != 8'h00) begin
            periph_ctl_q <= 1'b1; // R5
        end else if (soft_reset) begin
            periph_ctl_q <= 1'b0;
        end
    end

    // Interrupt mask and enables
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ext_mask_q <= 1'b0;
            irq_en_q <= 1'b0;
            dma_en_q <= dma_en_reset;
        end else if (soft_reset) begin
            ext_mask_q <= 1'b0;
            irq_en_q <= 1'b0;
            dma_en_q <= dma_en_reset;
        end else if (wr_stb && index == reg_mask_idx) begin
            ext_mask_q <= wbyte[mask_ext_bit]; // R7
        end else if (wr_stb && index == reg_irqdma_idx) begin
            irq_en_q <= wbyte[irq_en_bit]; // R8
            dma_en_q <= wbyte[3:0]; // R8
        end
    end

    // Output word: high byte staged, low byte write pushes the word.
    // Writing the low byte while the FIFO is full drops the word;
    // software polls register 0 first.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            out_hi_q <= 8'h00;
        end else if (soft_reset) begin
            out_hi_q <= 8'h00;
        end else if (wr_stb && index == reg_word_hi_idx) begin
            out_hi_q <= wbyte; // R9
        end
    end

    assign fifo_in_valid = wr_stb && (index == reg_word_lo_idx); // R9

    pio_fifo #(
        .width(word_width),
        .depth(fifo_depth)
    ) u_fifo (
        .mclk(mclk),
        .reset_n(reset_n),
        .flush(soft_reset),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data({out_hi_q, wbyte}),
        .out_valid(fifo_out_valid),
        .out_ready(output_ready),
        .out_data(fifo_out_data)
    );

    assign output_valid = fifo_out_valid;
    assign output_word = fifo_out_data;

    // Control outputs: only power-on reset touches them
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ctl_q <= ctl_out_reset;
        end else if (wr_stb && index == reg_lines_idx) begin
            ctl_q <= wbyte[1:0]; // R10 R11
        end
    end

    // Inverted sense: a stored 1 drives the line low
    assign control_output_zero = ~ctl_q[0]; // R10
    assign control_output_one = ~ctl_q[1]; // R10

    // Input word capture; reading the low byte frees the holding register
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            in_word_q <= 16'h0000;
            in_word_full_q <= 1'b0;
        end else if (soft_reset) begin
            in_word_full_q <= 1'b0;
        end else if (input_valid && input_ready) begin
            in_word_q <= input_word;
            in_word_full_q <= 1'b1;
        end else if (rd_stb && index == reg_word_lo_idx) begin
            in_word_full_q <= 1'b0;
        end
    end

    assign input_ready = !in_word_full_q;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            reset_pulse_q <= 1'b0;
        end else begin
            reset_pulse_q <= soft_reset; // R6
        end
    end

    assign card_reset_pulse = reset_pulse_q;
    assign peripheral_control_line = periph_ctl_q;
    assign dma_enables = dma_en_q;
    assign irq_request = irq_en_q && ext_mask_q
        && !periph_in.external_request_line; // R7 R8

    // Read multiplexer
    always_comb begin
        rd_byte = 8'h00; // R14
        case (index)
            reg_ready_idx: begin
                rd_byte = {7'h00, fifo_in_ready}; // R1
            end
            reg_ident_idx: begin
                rd_byte = card_ident_value; // R2
            end
            reg_irqdma_idx: begin
                rd_byte[irq_en_bit] = irq_en_q; // R13
                rd_byte[irq_req_bit] = irq_request; // R13
                rd_byte[level_hi_bit] = level_switch[1]; // R13
                rd_byte[level_lo_bit] = level_switch[0]; // R13
                rd_byte[3:0] = dma_en_q; // R13
            end
            reg_word_hi_idx: begin
                rd_byte = in_word_q[15:8]; // R3
            end
            reg_word_lo_idx: begin
                rd_byte = in_word_q[7:0]; // R3
            end
            reg_lines_idx: begin
                // Straight from the pins, no holding register
                rd_byte[ok_bit] = periph_in.peripheral_ok_line; // R4 R12
                rd_byte[ext_low_bit] =
                    !periph_in.external_request_line; // R4 R12
                rd_byte[sts1_low_bit] = !periph_in.status_input_one; // R4
                rd_byte[sts0_low_bit] = !periph_in.status_input_zero; // R4
            end
            reg_xfer_ctl_idx: begin
                rd_byte = {7'h00, periph_ctl_q};
            end
            reg_fifo_stat_idx: begin
                rd_byte = {6'h00, fifo_out_valid, in_word_full_q};
            end
            default: begin
                rd_byte = 8'h00; // R14
            end
        endcase
    end
endmodule : pio_card
`default_nettype wire

// ==== pio_card_assertions.sv ====
// Checker on the card's register port
`timescale 1ns/1ps
`default_nettype none
module pio_card_assertions (
    input wire logic mclk,
    input wire logic reset_n,
    input wire pio_pkg::apb_req_t apb_req,
    input wire pio_pkg::apb_rsp_t apb_rsp,
    input wire pio_pkg::periph_in_t periph_in,
    input wire logic peripheral_control_line,
    input wire logic control_output_zero,
    input wire logic control_output_one,
    input wire logic [3:0] dma_enables,
    input wire logic card_reset_pulse
);
    import pio_pkg::*;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    logic rd, wr;
    logic [9:0] ix;
    logic [1:0] ctl;
    logic [3:0] pl;
    logic [7:0] wb;
    assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign rd = apb_req.psel && apb_req.penable && !apb_req.pwrite;
    assign ix = apb_req.paddr[11:2];
    assign ctl = {control_output_one, control_output_zero};
    assign pl = periph_in;
    // Registers are one byte wide; upper write data is ignored
    assign wb = apb_req.pwdata[7:0];
    sequence s_pulse;
        card_reset_pulse ##1 !card_reset_pulse;
    endsequence
    a_ident_read: assert property (rd && ix == 10'h1 |->
        apb_rsp.prdata == {24'h0, card_ident_value}) else $error("ident");
    a_lines_read: assert property (rd && ix == 10'h7 |->
        apb_rsp.prdata == {28'h0, pl ^ 4'h7}) else $error("lines");
    a_undef_read: assert property (rd && (ix == 10'h2 || ix == 10'h6)
        |-> apb_rsp.prdata == 32'h0) else $error("undef");
    a_control_set: assert property (wr && ix == 10'h0 &&
        wb != 8'h00 |=> peripheral_control_line) else $error("pc_line");
    a_reset_pulse: assert property (wr && ix == 10'h1 &&
        wb != 8'h00 |=> s_pulse) else $error("pulse");
    a_ctl_write: assert property (wr && ix == 10'h7 |=>
        ctl == ~$past(apb_req.pwdata[1:0])) else $error("ctl");
    // Card reset must not disturb the lines
    a_ctl_hold: assert property (!(wr && ix == 10'h7) |=>
        $stable(ctl)) else $error("hold");
    a_dma_write: assert property (wr && ix == 10'h3 |=>
        dma_enables == $past(apb_req.pwdata[3:0])) else $error("dma");
endmodule : pio_card_assertions
bind pio_card pio_card_assertions chk_i (
    .mclk(mclk), .reset_n(reset_n), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .periph_in(periph_in),
    .peripheral_control_line(peripheral_control_line),
    .control_output_zero(control_output_zero),
    .control_output_one(control_output_one),
    .dma_enables(dma_enables), .card_reset_pulse(card_reset_pulse)
);
`default_nettype wire

// ==== pio_fifo.sv ====
// Parameterised valid/ready FIFO for the data path
`timescale 1ns/1ps
`default_nettype none
module pio_fifo #(
    parameter int width = 16,
    parameter int depth = 8
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [width-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [width-1:0] out_data
);
    localparam int aw = $clog2(depth);
    logic [width-1:0] mem_q [depth];
    logic [aw-1:0] wr_q;
    logic [aw-1:0] rd_q;
    logic [aw:0] count_q;
    logic push;
    logic pop;

    assign in_ready = (count_q != (aw+1)'(depth));
    assign out_valid = (count_q != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rd_q];

    always_ff @(posedge mclk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wr_q <= '0;
            rd_q <= '0;
            count_q <= '0;
        end else if (flush) begin
            wr_q <= '0;
            rd_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == aw'(depth-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == aw'(depth-1)) ? '0 : rd_q + 1'b1;
            end
            if (push && !pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop && !push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule : pio_fifo
`default_nettype wire

// ==== pio_peer.sv ====
// Peripheral model on the data lines
`timescale 1ns/1ps
`default_nettype none
module pio_peer (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic send,
    input wire logic [15:0] word,
    input wire logic stall,
    output logic [15:0] input_word,
    output logic input_valid,
    input wire logic input_ready,
    input wire logic [15:0] output_word,
    input wire logic output_valid,
    output logic output_ready
);
    logic v = 1'b0;
    logic [15:0] w = 16'h0;
    logic [15:0] got[$];
    assign input_word = w;
    assign input_valid = v;
    assign output_ready = !stall;
    // Idle data toggles so stale values never pass
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            v <= 1'b0;
        end else if (v && input_ready) begin
            v <= 1'b0;
            w <= ~w;
        end else if (send) begin
            v <= 1'b1;
            w <= word;
        end else if (!v) begin
            w <= ~w;
        end
    end
    always @(posedge mclk) begin
        if (reset_n && output_valid && output_ready) begin
            got.push_back(output_word);
        end
    end
endmodule : pio_peer
`default_nettype wire

// ==== pio_pkg.sv ====
// Package: register map, field positions and carrier types
package pio_pkg;
    localparam logic [4:0] reg_ready_idx = 5'h00;
    localparam logic [4:0] reg_ident_idx = 5'h01;
    localparam logic [4:0] reg_mask_idx = 5'h02;
    localparam logic [4:0] reg_irqdma_idx = 5'h03;
    localparam logic [4:0] reg_word_hi_idx = 5'h04;
    localparam logic [4:0] reg_word_lo_idx = 5'h05;
    localparam logic [4:0] reg_undef_idx = 5'h06;
    localparam logic [4:0] reg_lines_idx = 5'h07;
    // Extra status: control line readback and buffer state
    localparam logic [4:0] reg_xfer_ctl_idx = 5'h08;
    localparam logic [4:0] reg_fifo_stat_idx = 5'h09;
    // Arbitrary value
    localparam logic [7:0] card_ident_value = 8'h5a;
    localparam int irq_en_bit = 7;
    localparam int irq_req_bit = 6;
    localparam int level_hi_bit = 5;
    localparam int level_lo_bit = 4;
    localparam int mask_ext_bit = 0;
    localparam int ok_bit = 3;
    localparam int ext_low_bit = 2;
    localparam int sts1_low_bit = 1;
    localparam int sts0_low_bit = 0;
    localparam logic [3:0] dma_en_reset = 4'h0;
    localparam logic [1:0] ctl_out_reset = 2'h0;
    localparam int word_width = 16;
    localparam int fifo_depth = 8;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic peripheral_ok_line;
        logic external_request_line;
        logic status_input_one;
        logic status_input_zero;
    } periph_in_t;
endpackage : pio_pkg

// ==== tb_top.sv ====
// Bench for the parallel I/O card
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pio_pkg::*;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    apb_req_t req = '0;
    apb_rsp_t rsp;
    periph_in_t pin = '0;
    logic [1:0] lvl = 2'h2;
    logic send = 1'b0;
    logic stall = 1'b0;
    logic [15:0] word = 16'h0;
    logic [15:0] iw, ow;
    logic iv, ir, ov, orr, pc_line, c0, c1, irq, crp;
    logic [3:0] dma;
    logic [31:0] r;
    int fails = 0;
    int cmp_count = 0;
    always #2.5 mclk = ~mclk;
    pio_card DUT (.mclk(mclk), .reset_n(reset_n), .apb_req(req),
        .apb_rsp(rsp), .periph_in(pin), .level_switch(lvl),
        .input_word(iw), .input_valid(iv), .input_ready(ir),
        .output_word(ow), .output_valid(ov), .output_ready(orr),
        .peripheral_control_line(pc_line), .control_output_zero(c0),
        .control_output_one(c1), .irq_request(irq),
        .dma_enables(dma), .card_reset_pulse(crp));
    pio_peer peer (.mclk(mclk), .reset_n(reset_n), .send(send),
        .word(word), .stall(stall), .input_word(iw), .input_valid(iv),
        .input_ready(ir), .output_word(ow), .output_valid(ov),
        .output_ready(orr));
    task automatic chk(input string n, input logic [31:0] s, e);
        cmp_count++;
        if (s !== e) begin
            fails++;
            $display("ERROR %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [4:0] ix,
        input logic [31:0] d);
        @(posedge mclk);
        req <= '{1'b1, 1'b0, w, {5'h0, ix, 2'h0}, d};
        @(posedge mclk);
        req.penable <= 1'b1;
        do @(posedge mclk); while (rsp.pready !== 1'b1);
        r = rsp.prdata;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb
    task automatic rdc(input logic [4:0] ix, input logic [31:0] e);
        apb(1'b0, ix, 32'h0);
        chk($sformatf("reg %0d", ix), r, e);
    endtask : rdc
    task automatic t_regs;
        rdc(5'h01, {24'h0, card_ident_value});
        apb(1'b1, 5'h06, 32'hff);
        rdc(5'h06, 32'h0);
        rdc(5'h02, 32'h0);
        rdc(5'h00, 32'h1);
        for (int i = 0; i < 16; i++) begin
            pin <= periph_in_t'(i[3:0]);
            rdc(5'h07, {28'h0, i[3], ~i[2:0]});
        end
        $display("regs done");
    endtask : t_regs
    task automatic t_ctl;
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 5'h07, 32'hfc | i);
            #1 chk("ctl", {30'h0, c1, c0}, {30'h0, ~i[1:0]});
        end
        apb(1'b1, 5'h07, 32'h1);
        apb(1'b1, 5'h00, 32'h0);
        #1 chk("pc_line", {31'h0, pc_line}, 32'h0);
        apb(1'b1, 5'h00, 32'h80);
        #1 chk("pc_line", {31'h0, pc_line}, 32'h1);
        rdc(5'h08, 32'h1);
        apb(1'b1, 5'h03, 32'hf);
        apb(1'b1, 5'h01, 32'h1);
        #1 chk("pulse", {31'h0, crp}, 32'h1);
        @(posedge mclk);
        #1 chk("pulse", {31'h0, crp}, 32'h0);
        chk("pc_line", {31'h0, pc_line}, 32'h0);
        chk("dma", {28'h0, dma}, 32'h0);
        chk("ctl", {30'h0, c1, c0}, 32'h2);
        rdc(5'h01, {24'h0, card_ident_value});
        $display("ctl done");
    endtask : t_ctl
    task automatic t_irq;
        pin <= periph_in_t'(4'hb);
        apb(1'b1, 5'h02, 32'hff);
        apb(1'b1, 5'h03, 32'hff);
        #1 chk("dma", {28'h0, dma}, 32'hf);
        chk("irq", {31'h0, irq}, 32'h1);
        rdc(5'h03, 32'hef);
        // Request line high: no interrupt even with both enables set
        pin <= periph_in_t'(4'hf);
        lvl <= 2'h1;
        @(posedge mclk);
        #1 chk("irq", {31'h0, irq}, 32'h0);
        rdc(5'h03, 32'h9f);
        pin <= periph_in_t'(4'hb);
        apb(1'b1, 5'h02, 32'hfe);
        #1 chk("irq", {31'h0, irq}, 32'h0);
        $display("irq done");
    endtask : t_irq
    task automatic t_fifo;
        @(posedge mclk);
        stall <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            apb(1'b1, 5'h04, 32'h30 + i);
            apb(1'b1, 5'h05, 32'hc0 + i);
        end
        rdc(5'h00, 32'h0);
        rdc(5'h09, 32'h2);
        stall <= 1'b0;
        for (int k = 0; k < 40 && peer.got.size() < 8; k++)
            @(posedge mclk);
        chk("count", peer.got.size(), 32'h8);
        for (int i = 0; i < 8; i++)
            chk("out", {16'h0, peer.got[i]}, 32'h30c0 + 32'h101 * i);
        rdc(5'h00, 32'h1);
        $display("fifo done");
    endtask : t_fifo
    task automatic t_input;
        word <= 16'ha55a;
        send <= 1'b1;
        @(posedge mclk);
        send <= 1'b0;
        for (int k = 0; k < 20 && ir !== 1'b0; k++)
            @(posedge mclk);
        chk("in_rdy", {31'h0, ir}, 32'h0);
        rdc(5'h09, 32'h1);
        rdc(5'h04, 32'ha5);
        rdc(5'h05, 32'h5a);
        #1 chk("in_rdy", {31'h0, ir}, 32'h1);
        $display("input done");
    endtask : t_input
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        t_regs();
        t_ctl();
        t_irq();
        t_fifo();
        t_input();
        tally_and_finish();
    end
    initial begin
        #20000;
        fails++;
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
